/* File: hdl/cdbu_core.sv */
// debug entry capture, debug registers and breakpoint matching
`timescale 1ns/1ps
`default_nettype none
module cdbu_core
   import cdbu_pkg::*;
#(
   parameter int NUM_POINTS = 4,
   parameter int THREADS = 8,
   parameter int SCRATCH_WORDS = 8
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // tile configuration port onto the shared scratch words
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_index_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   // executing thread state
   input wire logic [2:0] thread_i,
   input wire logic instr_valid_i,
   input wire logic [31:0] pc_i,
   input wire logic mem_valid_i,
   input wire logic mem_load_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic res_valid_i,
   input wire logic [31:0] res_id_i,
   // saved state of the thread on entry
   input wire logic [31:0] saved_program_counter_i,
   input wire logic [31:0] saved_stack_pointer_i,
   input wire logic [31:0] saved_status_word_i,
   // other debug entry sources
   input wire logic host_request_i,
   input wire logic debug_call_instruction_i,
   input wire logic debug_return_i,
   output logic debug_entry_o,
   output logic debug_mode_o,
   output logic [THREADS-1:0] thread_stop_o
);
   // elaboration check: the register map is laid out for four points, eight threads, eight words
   if (NUM_POINTS != 4 || THREADS != 8 || SCRATCH_WORDS != 8) begin : g_bad_size
      $error("cdbu_core supports four points, eight threads, eight scratch words only");
   end
   cdbu_state_type state_r;
   logic [31:0] status_r;
   logic [31:0] saved_pc_r;
   logic [31:0] saved_sp_r;
   logic [7:0] fetch_thread_r;
   logic [4:0] fetch_index_r;
   logic [2:0] cause_code_r;
   logic [7:0] cause_thread_r;
   logic [1:0] cause_index_r;
   logic [31:0] entry_data_r;
   logic [7:0] stop_mask_r;
   logic [31:0] scratch_r [SCRATCH_WORDS];
   logic [31:0] ibrk_addr_r [NUM_POINTS];
   logic [31:0] ibrk_ctrl_r [NUM_POINTS];
   logic [31:0] dw_a_r [NUM_POINTS];
   logic [31:0] dw_b_r [NUM_POINTS];
   logic [31:0] dw_ctrl_r [NUM_POINTS];
   logic [31:0] rw_mask_r [NUM_POINTS];
   logic [31:0] rw_value_r [NUM_POINTS];
   logic [NUM_POINTS-1:0] ibrk_hit;
   logic [NUM_POINTS-1:0] dw_hit;
   logic [NUM_POINTS-1:0] rw_hit;
   logic entry_nxt;
   cdbu_cause_type cause_nxt;
   logic [1:0] index_nxt;
   logic [7:0] thread_nxt;
   logic [31:0] data_nxt;
   logic [31:0] rdata_nxt;
   logic [3:0] bank_sel;
   logic [2:0] scr_sel;
   // ===========================================================
   // comparators, three per breakpoint slot: instruction, data and resource, the resource one never armed as its control is tied to zero
   genvar gi;
   generate
      for (gi = 0; gi < NUM_POINTS; gi++) begin : g_pt
         cdbu_match_unit #(.THREADS(THREADS)) u_ibrk (
            .ctrl_i(ibrk_ctrl_r[gi]), .word_a_i(ibrk_addr_r[gi]), .word_b_i(WORD_RESET),
            .thread_i(thread_i), .instr_valid_i(instr_valid_i), .pc_i(pc_i),
            .mem_valid_i(1'b0), .mem_load_i(1'b0), .mem_addr_i(WORD_RESET),
            .res_valid_i(1'b0), .res_id_i(WORD_RESET),
            .ibrk_hit_o(ibrk_hit[gi]), .dwatch_hit_o(), .rwatch_hit_o());
         cdbu_match_unit #(.THREADS(THREADS)) u_dw (
            .ctrl_i(dw_ctrl_r[gi]), .word_a_i(dw_a_r[gi]), .word_b_i(dw_b_r[gi]),
            .thread_i(thread_i), .instr_valid_i(1'b0), .pc_i(WORD_RESET),
            .mem_valid_i(mem_valid_i), .mem_load_i(mem_load_i), .mem_addr_i(mem_addr_i),
            .res_valid_i(1'b0), .res_id_i(WORD_RESET),
            .ibrk_hit_o(), .dwatch_hit_o(dw_hit[gi]), .rwatch_hit_o());
         cdbu_match_unit #(.THREADS(THREADS)) u_rw (
            .ctrl_i(32'h00000000), .word_a_i(rw_mask_r[gi]), .word_b_i(rw_value_r[gi]),
            .thread_i(thread_i), .instr_valid_i(1'b0), .pc_i(WORD_RESET),
            .mem_valid_i(1'b0), .mem_load_i(1'b0), .mem_addr_i(WORD_RESET),
            .res_valid_i(res_valid_i), .res_id_i(res_id_i),
            .ibrk_hit_o(), .dwatch_hit_o(), .rwatch_hit_o(rw_hit[gi]));
      end
   endgenerate
   // ===========================================================
   // entry arbitration: host, call, then hardware points lowest first
   always_comb begin
      entry_nxt = 1'b0;
      cause_nxt = CDBU_CAUSE_NONE;
      index_nxt = 2'h0;
      thread_nxt = {5'h00, thread_i};
      data_nxt = entry_data_r;
      if (state_r == CDBU_RUN) begin
         if (host_request_i) begin
            entry_nxt = 1'b1;
            cause_nxt = CDBU_CAUSE_HOST;
            thread_nxt = 8'h00;
         end else if (debug_call_instruction_i) begin
            entry_nxt = 1'b1;
            cause_nxt = CDBU_CAUSE_CALL;
         end else if (|ibrk_hit) begin
            entry_nxt = 1'b1;
            cause_nxt = CDBU_CAUSE_IBRK;
            for (int i = NUM_POINTS - 1; i >= 0; i--) begin
               if (ibrk_hit[i]) begin
                  index_nxt = 2'(i);
               end
            end
         end else if (|dw_hit) begin
            entry_nxt = 1'b1;
            cause_nxt = CDBU_CAUSE_DWATCH;
            data_nxt = mem_addr_i;
            for (int i = NUM_POINTS - 1; i >= 0; i--) begin
               if (dw_hit[i]) begin
                  index_nxt = 2'(i);
               end
            end
         end else if (|rw_hit) begin
            entry_nxt = 1'b1;
            cause_nxt = CDBU_CAUSE_RWATCH;
            data_nxt = res_id_i;
            for (int i = NUM_POINTS - 1; i >= 0; i--) begin
               if (rw_hit[i]) begin
                  index_nxt = 2'(i);
               end
            end
         end
      end
   end
   // ===========================================================
   // debug mode state: entry halts, return resumes
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= CDBU_RUN;
         debug_entry_o <= 1'b0;
         debug_mode_o <= 1'b0;
      end else begin
         debug_entry_o <= entry_nxt;
         case (state_r)
            CDBU_RUN: begin
               if (entry_nxt) begin
                  state_r <= CDBU_HALTED;
                  debug_mode_o <= 1'b1;
               end
            end
            CDBU_HALTED: begin
               if (debug_return_i) begin
                  state_r <= CDBU_RUN;
                  debug_mode_o <= 1'b0;
               end
            end
            default: begin
               state_r <= CDBU_RUN;
               debug_mode_o <= 1'b0;
            end
         endcase
      end
   end
   // stop mask applies outside debug mode only; cleared from the entry edge so it never overlaps debug mode
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         thread_stop_o <= '0;
      end else if (entry_nxt || (state_r == CDBU_HALTED && !debug_return_i)) begin
         thread_stop_o <= '0;
      end else begin
         thread_stop_o <= stop_mask_r;
      end
   end
   // ===========================================================
   // captured context and cause; entry wins over a same-cycle write
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         saved_pc_r <= WORD_RESET;
         saved_sp_r <= WORD_RESET;
         status_r <= WORD_RESET;
         cause_code_r <= 3'h0;
         cause_thread_r <= 8'h00;
         cause_index_r <= 2'h0;
         entry_data_r <= WORD_RESET;
      end else if (entry_nxt) begin
         saved_pc_r <= saved_program_counter_i;
         saved_sp_r <= saved_stack_pointer_i;
         status_r <= saved_status_word_i & STATUS_RW_MASK;
         cause_code_r <= cause_nxt;
         cause_thread_r <= thread_nxt;
         cause_index_r <= index_nxt;
         entry_data_r <= data_nxt;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            REG_STATUS_OFS: status_r <= reg_wdata_i & STATUS_RW_MASK;
            REG_SAVED_PC_OFS: saved_pc_r <= reg_wdata_i;
            REG_SAVED_SP_OFS: saved_sp_r <= reg_wdata_i;
            REG_CAUSE_OFS: begin
               cause_code_r <= reg_wdata_i[2:0];
               cause_thread_r <= reg_wdata_i[CAUSE_THREAD_LSB +: 8];
               cause_index_r <= reg_wdata_i[CAUSE_INDEX_LSB +: 2];
            end
            REG_DATA_OFS: entry_data_r <= reg_wdata_i;
            default: ;
         endcase
      end
   end
   // ===========================================================
   // debugger-written operands, stop mask and point settings
   assign bank_sel = reg_addr_i[7:4];
   assign scr_sel = reg_addr_i[2:0];
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fetch_thread_r <= 8'h00;
         fetch_index_r <= 5'h00;
         stop_mask_r <= 8'h00;
         for (int i = 0; i < NUM_POINTS; i++) begin
            ibrk_addr_r[i] <= WORD_RESET;
            ibrk_ctrl_r[i] <= CTRL_RESET;
            dw_a_r[i] <= WORD_RESET;
            dw_b_r[i] <= WORD_RESET;
            dw_ctrl_r[i] <= CTRL_RESET;
            rw_mask_r[i] <= WORD_RESET;
            rw_value_r[i] <= WORD_RESET;
         end
      end else if (reg_wr_i) begin
         if (reg_addr_i == REG_FETCH_THREAD_OFS) fetch_thread_r <= reg_wdata_i[7:0];
         if (reg_addr_i == REG_FETCH_INDEX_OFS) fetch_index_r <= reg_wdata_i[4:0];
         if (reg_addr_i == REG_STOP_MASK_OFS) stop_mask_r <= reg_wdata_i[7:0];
         if (reg_addr_i[3:2] == 2'h0) begin
            case (bank_sel)
               REG_IBRK_ADDR_OFS[7:4]: ibrk_addr_r[reg_addr_i[1:0]] <= reg_wdata_i;
               REG_IBRK_CTRL_OFS[7:4]: ibrk_ctrl_r[reg_addr_i[1:0]] <= reg_wdata_i & 32'h00FF0003;
               REG_DWATCH_A_OFS[7:4]: dw_a_r[reg_addr_i[1:0]] <= reg_wdata_i;
               REG_DWATCH_B_OFS[7:4]: dw_b_r[reg_addr_i[1:0]] <= reg_wdata_i;
               REG_DWATCH_CTRL_OFS[7:4]: dw_ctrl_r[reg_addr_i[1:0]] <= reg_wdata_i & 32'h00FF0007;
               REG_RWATCH_MASK_OFS[7:4]: rw_mask_r[reg_addr_i[1:0]] <= reg_wdata_i;
               REG_RWATCH_VALUE_OFS[7:4]: rw_value_r[reg_addr_i[1:0]] <= reg_wdata_i;
               default: ;
            endcase
         end
      end
   end
   // scratch words shared with the tile configuration port; debug port wins a clash
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < SCRATCH_WORDS; i++) scratch_r[i] <= WORD_RESET;
         cfg_rdata_o <= WORD_RESET;
      end else begin
         if (reg_wr_i && reg_addr_i[7:3] == REG_SCRATCH_OFS[7:3]) begin
            scratch_r[scr_sel] <= reg_wdata_i;
         end else if (cfg_wr_i) begin
            scratch_r[cfg_index_i] <= cfg_wdata_i;
         end
         cfg_rdata_o <= scratch_r[cfg_index_i];
      end
   end
   // ===========================================================
   // read mux, one cycle latency; unmapped numbers read zero
   always_comb begin
      rdata_nxt = WORD_RESET;
      if (reg_addr_i[7:3] == REG_SCRATCH_OFS[7:3]) begin
         rdata_nxt = scratch_r[scr_sel];
      end else if (reg_addr_i[3:2] == 2'h0 && bank_sel >= 4'h3 && bank_sel <= 4'h9) begin
         case (bank_sel)
            REG_IBRK_ADDR_OFS[7:4]: rdata_nxt = ibrk_addr_r[reg_addr_i[1:0]];
            REG_IBRK_CTRL_OFS[7:4]: rdata_nxt = ibrk_ctrl_r[reg_addr_i[1:0]];
            REG_DWATCH_A_OFS[7:4]: rdata_nxt = dw_a_r[reg_addr_i[1:0]];
            REG_DWATCH_B_OFS[7:4]: rdata_nxt = dw_b_r[reg_addr_i[1:0]];
            REG_DWATCH_CTRL_OFS[7:4]: rdata_nxt = dw_ctrl_r[reg_addr_i[1:0]];
            REG_RWATCH_MASK_OFS[7:4]: rdata_nxt = rw_mask_r[reg_addr_i[1:0]];
            REG_RWATCH_VALUE_OFS[7:4]: rdata_nxt = rw_value_r[reg_addr_i[1:0]];
            default: rdata_nxt = WORD_RESET;
         endcase
      end else begin
         case (reg_addr_i)
            REG_STATUS_OFS: rdata_nxt = status_r;
            REG_SAVED_PC_OFS: rdata_nxt = saved_pc_r;
            REG_SAVED_SP_OFS: rdata_nxt = saved_sp_r;
            REG_FETCH_THREAD_OFS: rdata_nxt = {24'h000000, fetch_thread_r};
            REG_FETCH_INDEX_OFS: rdata_nxt = {27'h0000000, fetch_index_r};
            REG_CAUSE_OFS: rdata_nxt = {14'h0000, cause_index_r, cause_thread_r, 5'h00, cause_code_r};
            REG_DATA_OFS: rdata_nxt = entry_data_r;
            REG_STOP_MASK_OFS: rdata_nxt = {24'h000000, stop_mask_r};
            default: rdata_nxt = WORD_RESET;
         endcase
      end
   end
   // registered read answer, zero whenever no read was taken
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= WORD_RESET;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         reg_rdata_o <= reg_rd_i ? rdata_nxt : WORD_RESET;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/cdbu_pkg.sv */
// constants shared by the debug breakpoint unit
package cdbu_pkg;
   // ===========================================================
   // register numbers (8-bit processor-status register index)
   localparam logic [7:0] REG_STATUS_OFS = 8'h10;
   localparam logic [7:0] REG_SAVED_PC_OFS = 8'h11;
   localparam logic [7:0] REG_SAVED_SP_OFS = 8'h12;
   localparam logic [7:0] REG_FETCH_THREAD_OFS = 8'h13;
   localparam logic [7:0] REG_FETCH_INDEX_OFS = 8'h14;
   localparam logic [7:0] REG_CAUSE_OFS = 8'h15;
   localparam logic [7:0] REG_DATA_OFS = 8'h16;
   localparam logic [7:0] REG_STOP_MASK_OFS = 8'h18;
   localparam logic [7:0] REG_SCRATCH_OFS = 8'h20;
   localparam logic [7:0] REG_IBRK_ADDR_OFS = 8'h30;
   localparam logic [7:0] REG_IBRK_CTRL_OFS = 8'h40;
   localparam logic [7:0] REG_DWATCH_A_OFS = 8'h50;
   localparam logic [7:0] REG_DWATCH_B_OFS = 8'h60;
   localparam logic [7:0] REG_DWATCH_CTRL_OFS = 8'h70;
   localparam logic [7:0] REG_RWATCH_MASK_OFS = 8'h80;
   localparam logic [7:0] REG_RWATCH_VALUE_OFS = 8'h90;
   // ===========================================================
   // field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_LOAD_BIT = 2;
   localparam int CTRL_THREAD_LSB = 16;
   localparam int CAUSE_THREAD_LSB = 8;
   localparam int CAUSE_INDEX_LSB = 16;
   localparam logic [31:0] STATUS_RW_MASK = 32'h000006DF;
   // ===========================================================
   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   // ===========================================================
   // debug entry causes
   typedef enum logic [2:0] {
      CDBU_CAUSE_NONE = 3'h0,
      CDBU_CAUSE_HOST = 3'h1,
      CDBU_CAUSE_CALL = 3'h2,
      CDBU_CAUSE_IBRK = 3'h3,
      CDBU_CAUSE_DWATCH = 3'h4,
      CDBU_CAUSE_RWATCH = 3'h5
   } cdbu_cause_type;
   // debug mode state
   typedef enum logic [0:0] {
      CDBU_RUN = 1'b0,
      CDBU_HALTED = 1'b1
   } cdbu_state_type;
endpackage

/* File: hdl/cdbu_match_unit.sv */
// one breakpoint comparator: instruction, data or resource flavour
`timescale 1ns/1ps
`default_nettype none
module cdbu_match_unit
   import cdbu_pkg::*;
#(
   parameter int THREADS = 8
) (
   input wire logic [31:0] ctrl_i,
   input wire logic [31:0] word_a_i,
   input wire logic [31:0] word_b_i,
   input wire logic [2:0] thread_i,
   input wire logic instr_valid_i,
   input wire logic [31:0] pc_i,
   input wire logic mem_valid_i,
   input wire logic mem_load_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic res_valid_i,
   input wire logic [31:0] res_id_i,
   output logic ibrk_hit_o,
   output logic dwatch_hit_o,
   output logic rwatch_hit_o
);
   logic armed;
   logic cond_a;
   logic cond_b;
   // ===========================================================
   // gating by global and per-thread enable
   assign armed = ctrl_i[CTRL_ENABLE_BIT] & ctrl_i[CTRL_THREAD_LSB + thread_i];
   // instruction compare, equal or not equal
   assign ibrk_hit_o = armed & instr_valid_i &
      ((pc_i == word_a_i) ^ ctrl_i[CTRL_MODE_BIT]);
   // data conditions: A is address at or above first, B at or below second
   assign cond_a = mem_addr_i >= word_a_i;
   assign cond_b = mem_addr_i <= word_b_i;
   // stores always qualify, loads only when enabled
   assign dwatch_hit_o = armed & mem_valid_i & (~mem_load_i | ctrl_i[CTRL_LOAD_BIT]) &
      (ctrl_i[CTRL_MODE_BIT] ? (cond_a | cond_b) : (cond_a & cond_b));
   // masked resource identifier compare
   assign rwatch_hit_o = armed & res_valid_i &
      ((res_id_i & word_a_i) == (word_b_i & word_a_i));
endmodule
`default_nettype wire

/* File: tb/cdbu_core_monitor.sv */
// port checker for the debug breakpoint unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module cdbu_core_monitor
   import cdbu_pkg::*;
#(
   parameter int THREADS = 8
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_index_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic host_request_i,
   input wire logic debug_call_instruction_i,
   input wire logic debug_return_i,
   input wire logic debug_entry_o,
   input wire logic debug_mode_o,
   input wire logic [THREADS-1:0] thread_stop_o
);
   // one clock domain, checks quiet while reset is high
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // ===========================================================
   // debug entry and return
   property p_src_entry; !debug_mode_o && (host_request_i || debug_call_instruction_i) |=> debug_entry_o; endproperty
   a_src_entry: assert property (p_src_entry) else $error("request not taken");
   property p_entry_pulse; debug_entry_o |=> !debug_entry_o && debug_mode_o; endproperty
   a_entry_pulse: assert property (p_entry_pulse) else $error("entry pulse too long");
   // a halted core must not overwrite the recorded cause
   property p_ignore; debug_mode_o |=> !debug_entry_o; endproperty
   a_ignore: assert property (p_ignore) else $error("entry while halted");
   property p_return; debug_mode_o && debug_return_i |=> !debug_mode_o; endproperty
   a_return: assert property (p_return) else $error("return not taken");
   property p_stop_zero; debug_mode_o |-> thread_stop_o == '0; endproperty
   a_stop_zero: assert property (p_stop_zero) else $error("threads stopped in debug");
   // ===========================================================
   // register port
   property p_read_answer; reg_rd_i |=> reg_rvalid_o; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_read_idle; !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 32'h0; endproperty
   a_read_idle: assert property (p_read_idle) else $error("stray read data");
   // shared storage: a debugger write shows on the tile side two edges later
   property p_scratch; reg_wr_i && reg_addr_i == REG_SCRATCH_OFS && cfg_index_i == 3'h0 && !cfg_wr_i
      ##1 cfg_index_i == 3'h0 && !cfg_wr_i |=> cfg_rdata_o == $past(reg_wdata_i, 2); endproperty
   a_scratch: assert property (p_scratch) else $error("scratch not shared");
endmodule
bind cdbu_core cdbu_core_monitor #(.THREADS(THREADS)) mon (
   .core_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
   .cfg_wr_i, .cfg_index_i, .cfg_rdata_o, .host_request_i, .debug_call_instruction_i, .debug_return_i,
   .debug_entry_o, .debug_mode_o, .thread_stop_o
);
`default_nettype wire

/* File: tb/cdbu_debugger_model.sv */
// debugger model driving the register port of the debug unit
`timescale 1ns/1ps
`default_nettype none
module cdbu_debugger_model (
   input wire logic core_clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [31:0] reg_wdata_o,
   input wire logic [31:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   // port idle from time zero
   initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 42'h0;
   // ===========================================================
   // one-cycle strobes; address and data scrambled once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge core_clk_i);
      {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
      @(negedge core_clk_i);
      {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b0, ~a, ~d};
   endtask
   // answer stands for one cycle only, so it is taken before the strobe is released
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge core_clk_i);
      {reg_rd_o, reg_addr_o} = {1'b1, a};
      @(negedge core_clk_i);
      d = reg_rvalid_i ? reg_rdata_i : 32'hDEADBEEF;
      {reg_rd_o, reg_addr_o} = {1'b0, ~a};
   endtask
endmodule
`default_nettype wire

/* File: tb/core_debug_breakpoint_unit_test.sv */
// self-checking bench for the debug breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module core_debug_breakpoint_unit_test
   import cdbu_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic reg_wr_i, reg_rd_i, reg_rvalid_o, cfg_wr_i, instr_valid_i, mem_valid_i, mem_load_i;
   logic host_request_i, debug_call_instruction_i, debug_return_i, debug_entry_o, debug_mode_o;
   logic [2:0] cfg_index_i, thread_i;
   logic [7:0] reg_addr_i, thread_stop_o;
   logic [31:0] reg_wdata_i, reg_rdata_o, cfg_wdata_i, cfg_rdata_o, pc_i, mem_addr_i;
   logic [31:0] saved_program_counter = 32'h00401230, saved_stack_pointer = 32'h0007FF00, saved_status_word = 32'hFFFFFFFF;
   int n_errors = 0;
   int checks_done = 0;
   // 125 MHz core clock
   always #4 core_clk_i = ~core_clk_i;
   cdbu_debugger_model dbg (
      .core_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o)
   );
   // resource watchpoints cannot fire in this build, so their inputs stay quiet
   cdbu_core dut (
      .core_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
      .cfg_wr_i, .cfg_index_i, .cfg_wdata_i, .cfg_rdata_o, .thread_i, .instr_valid_i, .pc_i, .mem_valid_i,
      .mem_load_i, .mem_addr_i, .res_valid_i(1'b0), .res_id_i(32'h0), .saved_program_counter_i(saved_program_counter),
      .saved_stack_pointer_i(saved_stack_pointer), .saved_status_word_i(saved_status_word), .host_request_i, .debug_call_instruction_i,
      .debug_return_i, .debug_entry_o, .debug_mode_o, .thread_stop_o
   );
   // ===========================================================
   // helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      dbg.rd(a, d);
      chk(d, exp);
   endtask
   // one-cycle trigger k = {host, call, instr, mem, load}, then the entry pulse
   task automatic ev(input logic [2:0] th, input logic [31:0] a, input logic [4:0] k, input logic exp);
      {thread_i, pc_i, mem_addr_i} = {th, a, a};
      {host_request_i, debug_call_instruction_i, instr_valid_i, mem_valid_i, mem_load_i} = k;
      @(negedge core_clk_i);
      {host_request_i, debug_call_instruction_i, instr_valid_i, mem_valid_i} = 4'h0;
      chk(32'(debug_entry_o), 32'(exp));
   endtask
   // leave debug; the stop mask must hold its threads again
   task automatic ret;
      debug_return_i = 1'b1;
      @(negedge core_clk_i);
      debug_return_i = 1'b0;
      chk({24'h0, thread_stop_o}, 32'h000000A5);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ===========================================================
   // scenarios
   task automatic t_regs;
      rchk(8'h15, 32'h0);
      rchk(8'h40, 32'h0);
      rchk(8'h73, 32'h0);
      rchk(8'h17, 32'h0);
      dbg.wr(8'h13, 32'hFFFFFFFF);
      dbg.wr(8'h14, 32'hFFFFFFFF);
      rchk(8'h13, 32'h000000FF);
      rchk(8'h14, 32'h0000001F);
      dbg.wr(8'h83, 32'hF0F0A5A5);
      rchk(8'h83, 32'hF0F0A5A5);
      {cfg_wr_i, cfg_index_i, cfg_wdata_i} = {1'b1, 3'h5, 32'h2468ACE0};
      @(negedge core_clk_i);
      {cfg_wr_i, cfg_index_i} = 4'h0;
      rchk(8'h25, 32'h2468ACE0);
      dbg.wr(8'h20, 32'h13579BDF);
      @(negedge core_clk_i);
      chk(cfg_rdata_o, 32'h13579BDF);
      $display("register test done");
   endtask
   task automatic t_entry;
      dbg.wr(8'h18, 32'h000000A5);
      @(negedge core_clk_i);
      chk({24'h0, thread_stop_o}, 32'h000000A5);
      ev(3'h3, 32'h0, 5'h10, 1'b1);
      ev(3'h3, 32'h0, 5'h08, 1'b0);
      chk({24'h0, thread_stop_o}, 32'h0);
      rchk(8'h11, saved_program_counter);
      rchk(8'h12, saved_stack_pointer);
      rchk(8'h10, saved_status_word & STATUS_RW_MASK);
      rchk(8'h15, 32'h00000001);
      dbg.wr(8'h11, 32'h00C0FFEE);
      rchk(8'h11, 32'h00C0FFEE);
      ret();
      ev(3'h6, 32'h0, 5'h08, 1'b1);
      rchk(8'h15, 32'h00000602);
      ret();
      $display("entry test done");
   endtask
   // bp1 breaks on inequality, bp2 and bp3 on equality, all for thread 2 only
   task automatic t_ibrk;
      for (int i = 1; i < 4; i++) begin
         dbg.wr(8'h30 + 8'(i), 32'h00000400);
         dbg.wr(8'h40 + 8'(i), (i == 1) ? 32'h00040003 : 32'h00040001);
      end
      ev(3'h2, 32'h00000400, 5'h04, 1'b1);
      rchk(8'h15, 32'h00020203);
      ret();
      ev(3'h5, 32'h00000404, 5'h04, 1'b0);
      ev(3'h2, 32'h00000404, 5'h04, 1'b1);
      rchk(8'h15, 32'h00010203);
      ret();
      $display("instruction breakpoint test done");
   endtask
   task automatic t_dwatch;
      dbg.wr(8'h51, 32'h00001000);
      dbg.wr(8'h61, 32'h00001FFF);
      dbg.wr(8'h71, 32'h00020001);
      ev(3'h1, 32'h00001800, 5'h02, 1'b1);
      rchk(8'h15, 32'h00010104);
      rchk(8'h16, 32'h00001800);
      ret();
      ev(3'h1, 32'h00001800, 5'h03, 1'b0);
      ev(3'h1, 32'h00003000, 5'h02, 1'b0);
      dbg.wr(8'h71, 32'h00020007);
      ev(3'h1, 32'h00003000, 5'h03, 1'b1);
      rchk(8'h16, 32'h00003000);
      ret();
      $display("data watchpoint test done");
   endtask
   // main sequence, inputs moved on falling edges
   initial begin
      {cfg_wr_i, cfg_index_i, cfg_wdata_i, thread_i, pc_i, mem_addr_i} = 103'h0;
      {instr_valid_i, mem_valid_i, mem_load_i, host_request_i, debug_call_instruction_i, debug_return_i} = 6'h00;
      repeat (3) @(negedge core_clk_i);
      reset_i = 1'b0;
      t_regs();
      t_entry();
      t_ibrk();
      t_dwatch();
      end_of_test();
   end
   // watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      #16000;
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
`default_nettype wire
